// *** hdl/gpa_port.sv ***
// General-purpose pin port with alternate functions and host registers
`timescale 1ns/1ps
module gpa_port
    import gpa_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire gpa_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    input wire logic host_interrupt_request,
    input wire logic sync_pulse_out,
    input wire logic ant_two_pin_mode,
    input wire logic ant_dev_drives,
    output logic antenna_link_input
);
    logic [7:0] fsel_r;
    logic [7:0] dout_r;
    logic [7:0] dir_r;
    logic [7:0] in_sample_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [7:0] pin_out_r;
    logic [7:0] pin_oe_r;
    logic ant_in_r;

    wire wr_fsel = req.wr && (req.addr == GPA_OFF_FSEL);
    wire wr_dout = req.wr && (req.addr == GPA_OFF_DOUT);
    wire wr_dir = req.wr && (req.addr == GPA_OFF_DIR);
    wire sel7 = fsel_r[GPA_BIT_PIN7_SEL];
    wire sel65 = fsel_r[GPA_BIT_PIN65_SEL];

    // Only the two select bits are stored; the rest stay zero
    wire [7:0] fsel_nxt = wr_fsel ? (req.wdata & GPA_FSEL_MASK) : fsel_r;
    wire [7:0] dout_nxt = wr_dout ? req.wdata : dout_r;
    wire [7:0] dir_nxt = wr_dir ? req.wdata : dir_r;

    // Per-pin alternate sources
    gpa_alt_t alt [8];
    assign alt[7] = '{en: sel7, oe: 1'h1, val: host_interrupt_request};
    assign alt[6] = '{en: sel65, oe: 1'h0, val: 1'h0};
    assign alt[5] = '{en: sel65, oe: 1'h1, val: sync_pulse_out};
    assign alt[4] = '{en: 1'h0, oe: 1'h0, val: 1'h0};
    assign alt[3] = '{en: 1'h0, oe: 1'h0, val: 1'h0};
    assign alt[2] = '{en: 1'h0, oe: 1'h0, val: 1'h0};
    // Pin 1 never serves plain I/O; it drives only in single-pin antenna mode
    assign alt[1] = '{en: 1'h1, oe: ~ant_two_pin_mode, val: ant_dev_drives};
    // In two-pin mode pin 0 is released and listened to
    assign alt[0] = '{en: ant_two_pin_mode, oe: 1'h0, val: 1'h0};

    logic [7:0] pin_out_nxt;
    logic [7:0] pin_oe_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            gpa_pin_cell u_cell (
                .alt(alt[gi]),
                .gp_dir(dir_r[gi]),
                .gp_data(dout_r[gi]),
                .pin_val(pin_out_nxt[gi]),
                .pin_en(pin_oe_nxt[gi])
            );
        end
    endgenerate

    // Register read selection; unmapped offsets answer zero
    wire [7:0] rdata_nxt =
        (req.addr == GPA_OFF_FSEL) ? (fsel_r & GPA_FSEL_MASK) :
        (req.addr == GPA_OFF_DOUT) ? dout_r :
        (req.addr == GPA_OFF_DIR) ? dir_r :
        (req.addr == GPA_OFF_DIN) ? (in_sample_r & GPA_DIN_MASK) :
        GPA_UNMAPPED;

    always_ff @(posedge clk) begin
        if (rst) begin
            fsel_r <= GPA_RST_FSEL;
            dout_r <= GPA_RST_DOUT;
            dir_r <= GPA_RST_DIR;
        end else begin
            fsel_r <= fsel_nxt;
            dout_r <= dout_nxt;
            dir_r <= dir_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'h0;
        end else begin
            rdata_r <= req.rd ? rdata_nxt : 8'h00;
            rvalid_r <= req.rd;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            in_sample_r <= 8'h00;
            ant_in_r <= 1'h0;
            pin_out_r <= 8'h00;
            pin_oe_r <= 8'h00;
        end else begin
            in_sample_r <= pin_in;
            ant_in_r <= ant_two_pin_mode ? pin_in[0] : 1'h0;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign rdata = rdata_r;
    assign rvalid = rvalid_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign antenna_link_input = ant_in_r;

    // Checks
    sequence s_rd_fsel;
        req.rd && (req.addr == GPA_OFF_FSEL) ##1 rvalid;
    endsequence

    sequence s_rd_din;
        req.rd && (req.addr == GPA_OFF_DIN) ##1 rvalid;
    endsequence

    a_reset_values: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> (fsel_r == GPA_RST_FSEL) && (dout_r == GPA_RST_DOUT)
            && (dir_r == GPA_RST_DIR))
        else $error("registers not at reset values after reset");

    a_pin7_irq: assert property (@(posedge clk) disable iff (rst)
        sel7 |=> pin_oe[7] && (pin_out[7] == $past(host_interrupt_request)))
        else $error("pin 7 does not carry interrupt request");

    a_pin5_sync: assert property (@(posedge clk) disable iff (rst)
        sel65 |=> pin_oe[5] && !pin_oe[6] && (pin_out[5] == $past(sync_pulse_out)))
        else $error("pins 6 and 5 wrong in alternate mode");

    a_pin1_dir: assert property (@(posedge clk) disable iff (rst)
        (!rst && !ant_two_pin_mode) |=> pin_oe[1] && (pin_out[1] == $past(ant_dev_drives)))
        else $error("pin 1 does not show antenna direction");

    a_pin0_link: assert property (@(posedge clk) disable iff (rst)
        (!rst && ant_two_pin_mode) |=> !pin_oe[0] && (antenna_link_input == $past(pin_in[0])))
        else $error("pin 0 not routed to antenna link input");

    a_gp_drive: assert property (@(posedge clk) disable iff (rst)
        1'h1 |=> (pin_oe[3] == !$past(dir_r[3])) && (pin_out[3] == $past(dout_r[3])))
        else $error("plain pin 3 does not follow data and direction");

    a_gp_override: assert property (@(posedge clk) disable iff (rst)
        (!sel7 && !dir_r[7]) ##1 sel7 |=> pin_oe[7]
            && (pin_out[7] == $past(host_interrupt_request)))
        else $error("alternate source did not override pin 7");

    a_dir_write: assert property (@(posedge clk) disable iff (rst)
        wr_dir ##1 !wr_dir |=> pin_oe[2] == !$past(req.wdata[2], 2))
        else $error("direction write did not set pin 2 enable");

    a_fsel_rd_zero: assert property (@(posedge clk) disable iff (rst)
        s_rd_fsel |-> rdata[5:0] == 6'h00)
        else $error("reserved select bits read nonzero");

    a_din_read: assert property (@(posedge clk) disable iff (rst)
        s_rd_din |-> (rdata == ($past(in_sample_r) & GPA_DIN_MASK)) && !rdata[1])
        else $error("input data read wrong");

    // Register stores and readback
    sequence s_rd_dir;
        req.rd && (req.addr == GPA_OFF_DIR) ##1 rvalid;
    endsequence

    sequence s_rd_dout;
        req.rd && (req.addr == GPA_OFF_DOUT) ##1 rvalid;
    endsequence

    sequence s_wr_din;
        req.wr && (req.addr == GPA_OFF_DIN);
    endsequence

    a_fsel_store: assert property (@(posedge clk) disable iff (rst)
        wr_fsel |=> (fsel_r[5:0] == 6'h00) && (fsel_r[7:6] == $past(req.wdata[7:6])))
        else $error("select write stored wrong bits");

    a_dout_write: assert property (@(posedge clk) disable iff (rst)
        wr_dout |=> dout_r == $past(req.wdata))
        else $error("output data write not stored");

    a_dout_readback: assert property (@(posedge clk) disable iff (rst)
        s_rd_dout |-> rdata == $past(dout_r))
        else $error("output data read wrong");

    a_dir_readback: assert property (@(posedge clk) disable iff (rst)
        s_rd_dir |-> rdata == $past(dir_r))
        else $error("direction read wrong");

    // The input register is read-only; a write to it must leave every register alone
    a_din_wr_ignored: assert property (@(posedge clk) disable iff (rst)
        s_wr_din |=> $stable(fsel_r) && $stable(dout_r) && $stable(dir_r))
        else $error("write to input register changed state");

    // Plain I/O paths while no alternate function is selected, and pin 1 released in two-pin mode
    a_pin7_plain: assert property (@(posedge clk) disable iff (rst)
        (!sel7 && !dir_r[7]) |=> pin_oe[7] && (pin_out[7] == $past(dout_r[7])))
        else $error("pin 7 not plain I/O with select clear");

    a_pin5_plain: assert property (@(posedge clk) disable iff (rst)
        (!sel65 && !dir_r[5]) |=> pin_oe[5] && (pin_out[5] == $past(dout_r[5])))
        else $error("pin 5 not plain I/O with select clear");

    a_pin6_plain: assert property (@(posedge clk) disable iff (rst)
        !sel65 |=> pin_oe[6] == !$past(dir_r[6]))
        else $error("pin 6 enable does not follow direction");

    a_pin0_plain: assert property (@(posedge clk) disable iff (rst)
        (!rst && !ant_two_pin_mode) |=> (pin_oe[0] == !$past(dir_r[0]))
            && (pin_out[0] == $past(dout_r[0])) && !antenna_link_input)
        else $error("pin 0 not plain I/O in single-pin mode");

    a_pin1_release: assert property (@(posedge clk) disable iff (rst)
        (!rst && ant_two_pin_mode) |=> !pin_oe[1])
        else $error("pin 1 driven in two-pin mode");

    // An input direction bit must not keep the alternate source off the pin
    a_pin5_override: assert property (@(posedge clk) disable iff (rst)
        (sel65 && dir_r[5]) |=> pin_oe[5])
        else $error("sync output blocked by direction bit");

endmodule

// *** hdl/gpa_pkg.sv ***
// Package for the general-purpose pin port: register map, reset values, carriers
// Notes on behaviour
// - Function bit 7 set drives pin 7 with the host interrupt request, else plain I/O.
// - Function bit 6 governs pins 6 and 5; set gives sync pulse on 5, 6 reserved.
// - Function register resets to zero; bits 5 to 0 read back as zero.
// - Pin 1 shows antenna line direction in single-pin mode: 1 device drives antenna.
// - Pin 0 becomes the antenna link input in two-pin mode, else plain I/O.
// - Output data bits set driven pin levels for pins 7-2 and 0; reset zero.
// - Direction bit 0 means output, 1 means input; register resets to all ones.
// - Input data register returns sampled pin levels; bit 1 reads zero.
package gpa_pkg;

    localparam logic [7:0] GPA_OFF_FSEL = 8'h4F;
    localparam logic [7:0] GPA_OFF_DOUT = 8'h50;
    localparam logic [7:0] GPA_OFF_DIR = 8'h51;
    localparam logic [7:0] GPA_OFF_DIN = 8'h52;

    localparam logic [7:0] GPA_RST_FSEL = 8'h00;
    localparam logic [7:0] GPA_RST_DOUT = 8'h00;
    localparam logic [7:0] GPA_RST_DIR = 8'hFF;

    localparam logic [7:0] GPA_FSEL_MASK = 8'hC0;
    localparam logic [7:0] GPA_DIN_MASK = 8'hFD;
    localparam logic [7:0] GPA_UNMAPPED = 8'h00;

    localparam int GPA_BIT_PIN7_SEL = 7;
    localparam int GPA_BIT_PIN65_SEL = 6;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpa_req_t;

    typedef struct packed {
        logic en;
        logic oe;
        logic val;
    } gpa_alt_t;

endpackage

// *** hdl/gpa_pin_cell.sv ***
// One pin's source selection between plain I/O and its alternate function
`timescale 1ns/1ps
module gpa_pin_cell
    import gpa_pkg::*;
(
    input wire gpa_alt_t alt,
    input wire logic gp_dir,
    input wire logic gp_data,
    output logic pin_val,
    output logic pin_en
);
    // Alternate source wins over data and direction bits
    assign pin_val = alt.en ? alt.val : gp_data;
    assign pin_en = alt.en ? alt.oe : ~gp_dir;
endmodule

// *** sim/gpa_board.sv ***
// Board model: resolves each pin from device drive, external drive and pull-ups
`timescale 1ns/1ps
module gpa_board (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_lvl
);
    // A pin nobody drives floats to the board pull-up
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule

// *** sim/tb_gpa_port.sv ***
// Testbench for the general-purpose pin port
`timescale 1ns/1ps
module tb_gpa_port;
    import gpa_pkg::*;
    logic clk, rst, irq, sync, two_pin, dev_drv, link_in, rvalid;
    logic [7:0] rdata, pin_out, pin_oe, pin_lvl, ext_val, ext_en;
    gpa_req_t req;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    gpa_port dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .host_interrupt_request(irq),
        .sync_pulse_out(sync), .ant_two_pin_mode(two_pin), .ant_dev_drives(dev_drv),
        .antenna_link_input(link_in));
    gpa_board board_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_lvl(pin_lvl));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{rd: 1'h0, wr: 1'h1, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{rd: 1'h1, wr: 1'h0, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        rst = 1'h1;
        req = '0;
        irq = 1'h0;
        sync = 1'h0;
        two_pin = 1'h1;
        dev_drv = 1'h0;
        ext_val = 8'h00;
        ext_en = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        rd(GPA_OFF_FSEL, 8'h00);
        rd(GPA_OFF_DOUT, 8'h00);
        rd(GPA_OFF_DIR, 8'hFF);
        chk(pin_oe, 8'h00);
        wr(GPA_OFF_FSEL, 8'hFF);
        rd(GPA_OFF_FSEL, 8'hC0);
        wr(GPA_OFF_DOUT, 8'h5A);
        wr(GPA_OFF_DIR, 8'h00);
        wr(GPA_OFF_DIN, 8'h12);
        rd(8'h60, 8'h00);
        rd(GPA_OFF_DOUT, 8'h5A);
        @(posedge clk);
        irq <= 1'h1;
        sync <= 1'h1;
        settle();
        chk(pin_oe, 8'hBC);
        chk(pin_out & pin_oe, 8'hB8);
        @(posedge clk);
        irq <= 1'h0;
        sync <= 1'h0;
        settle();
        chk(pin_out & pin_oe, 8'h18);
        wr(GPA_OFF_FSEL, 8'h00);
        settle();
        chk(pin_oe, 8'hFC);
        chk(pin_out & pin_oe, 8'h58);
        // Select pin 7 while it is a driven plain output: the request must win
        @(posedge clk);
        irq <= 1'h1;
        wr(GPA_OFF_FSEL, 8'h80);
        settle();
        chk(pin_oe, 8'hFC);
        chk(pin_out & pin_oe, 8'hD8);
        @(posedge clk);
        irq <= 1'h0;
        wr(GPA_OFF_FSEL, 8'h00);
        @(posedge clk);
        ext_en <= 8'h01;
        ext_val <= 8'h01;
        settle();
        chk({7'h00, link_in}, 8'h01);
        @(posedge clk);
        ext_val <= 8'h00;
        settle();
        chk({7'h00, link_in}, 8'h00);
        @(posedge clk);
        two_pin <= 1'h0;
        dev_drv <= 1'h1;
        settle();
        chk({6'h00, pin_oe[1], pin_out[1]}, 8'h03);
        chk({6'h00, pin_oe[0], pin_out[0]}, 8'h02);
        @(posedge clk);
        dev_drv <= 1'h0;
        settle();
        chk({6'h00, pin_oe[1], pin_out[1]}, 8'h02);
        @(posedge clk);
        two_pin <= 1'h1;
        wr(GPA_OFF_DIR, 8'hFF);
        ext_en <= 8'hFF;
        ext_val <= 8'hC3;
        settle();
        rd(GPA_OFF_DIN, 8'hC1);
        rd(GPA_OFF_DIR, 8'hFF);
        // Reset in mid-run must bring every register back to its reset value
        wr(GPA_OFF_FSEL, 8'hC0);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(GPA_OFF_FSEL, 8'h00);
        rd(GPA_OFF_DOUT, 8'h00);
        rd(GPA_OFF_DIR, 8'hFF);
        complete_run();
    end
endmodule
